// ===== dv/sas_assertions.sv
// Checker: timing of the shared data line watched at the interface
`timescale 1ns/1ps
module sas_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dev_do,
  input wire logic dev_oe_n,
  input wire logic host_do,
  input wire logic host_oe_n,
  input wire logic data
);
  logic       sclk_ff;
  logic [5:0] falls_ff;
  logic [5:0] nxt_falls;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Falling sclk edges since select; cleared while deselected
  always_comb begin
    nxt_falls = falls_ff;
    if (cs_n) begin
      nxt_falls = 6'h00;
    end else if (sclk_ff && !sclk) begin
      nxt_falls = falls_ff + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_ff  <= 1'b0;
      falls_ff <= 6'h00;
    end else begin
      sclk_ff  <= sclk;
      falls_ff <= nxt_falls;
    end
  end

  AST_TAKE_FOURTH: assert property ($fell(dev_oe_n) |-> falls_ff == 6'h04)
    else $error("device took the line at the wrong falling edge");
  AST_LINE_LOW: assert property ($fell(dev_oe_n) |-> !data)
    else $error("shared line not low at take-over");
  AST_DRIVE_LOW: assert property ($fell(dev_oe_n) |-> !dev_do [*8])
    else $error("null bit not driven low");
  AST_NO_CLASH: assert property (dev_oe_n || host_oe_n)
    else $error("both ends drive the data line");
  AST_HOST_FIRST: assert property ($fell(dev_oe_n) |-> $past(host_oe_n, 2))
    else $error("host still driving at take-over");
  AST_SHUTDOWN: assert property (cs_n && $past(cs_n, 6) |-> dev_oe_n)
    else $error("device drives while deselected");
  AST_DEV_LAUNCH: assert property (!dev_oe_n && $changed(dev_do) |-> !sclk)
    else $error("device bit changed with clock high");
  AST_HOST_LAUNCH: assert property (!host_oe_n && $changed(host_do) |-> !sclk)
    else $error("host bit changed with clock high");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> falls_ff == 6'h14 && $fell(sclk))
    else $error("frame length off");
endmodule : sas_assertions

// ===== dv/serial_adc_shared_line_sampling_test.sv
// Testbench: both link ends joined, frames run from a table
`timescale 1ns/1ps
module serial_adc_shared_line_sampling_test;
  logic        clk;
  logic        rst;
  logic        start;
  logic [2:0]  cfg;
  logic [7:0]  sample_code;
  logic [1:0]  chan_sel;
  logic        sample_window;
  logic        converting;
  logic        awake;
  logic [15:0] rx_data;
  logic        done;
  logic        busy;
  logic        sclk_q;
  logic [15:0] win_falls;
  logic [15:0] conv_falls;
  int          error_cnt;
  int          check_count;
  int          cyc;
  // Rows: {cfg, converted code}; every cfg value appears once
  logic [10:0] rows [8] = '{11'h1a5, 11'h0a5, 11'h601, 11'h380,
                            11'h4ff, 11'h500, 11'h23c, 11'h75a};

  sas_if lnk();
  sas_dev sas_dev_inst (.clk(clk), .rst(rst), .lnk(lnk), .sample_code(sample_code),
    .chan_sel(chan_sel), .sample_window(sample_window), .converting(converting),
    .awake(awake));
  // Short counts keep each frame near 260 cycles
  sas_host #(.WAKE_CYC(4), .HALF_CYC(5)) sas_host_inst (.clk(clk), .rst(rst), .lnk(lnk),
    .start(start), .cfg(cfg), .rx_data(rx_data), .done(done), .busy(busy));
  sas_assertions sas_assertions_inst (.clk(clk), .rst(rst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .dev_do(lnk.dev_do), .dev_oe_n(lnk.dev_oe_n),
    .host_do(lnk.host_do), .host_oe_n(lnk.host_oe_n), .data(lnk.data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Count sclk falls inside the window and the conversion; cut a hang short
  always @(posedge clk) begin
    sclk_q <= lnk.sclk;
    cyc <= cyc + 1;
    if (busy !== 1'b1) begin
      win_falls  <= 16'h0;                                 // Fresh counts for every frame
      conv_falls <= 16'h0;
    end else begin
      if (sclk_q && !lnk.sclk && sample_window === 1'b1) win_falls <= win_falls + 16'h1;
      if (sclk_q && !lnk.sclk && converting === 1'b1) conv_falls <= conv_falls + 16'h1;
    end
    if (cyc > 6000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Result MSB first, then LSB-first copy sharing the LSB, or zeros
  function automatic logic [15:0] expect_rx(input logic [2:0] c, input logic [7:0] v);
    logic [15:0] r;
    r = {v, 8'h00};
    if (!c[0]) begin
      for (int i = 1; i < 8; i++) r[8 - i] = v[i];
    end
    return r;
  endfunction : expect_rx

  // One frame; extra sends a second start in mid-frame, which must be ignored
  task automatic frame(input logic [2:0] c, input logic [7:0] v, input logic extra);
    int n;
    @(negedge clk);
    cfg = c;
    sample_code = v;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    if (extra) begin
      repeat (60) @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
    end
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(16'(done), 16'h1);
    check(rx_data, expect_rx(c, v));
    check(16'(chan_sel), 16'(c[2:1]));
    // Window spans the order bit's launch fall and closes on the hold fall
    check(win_falls, 16'h2);
    check(conv_falls, 16'h8);
    repeat (12) @(negedge clk);
    check(16'(awake), 16'h0);
    check(16'(busy), 16'h0);
    $display("frame cfg %h code %h finished", c, v);
  endtask : frame

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    rst = 1'b1;
    start = 1'b0;
    cfg = 3'h0;
    sample_code = 8'h00;
    error_cnt = 0;
    check_count = 0;
    repeat (8) @(negedge clk);
    check(16'({lnk.cs_n, lnk.sclk, lnk.dev_oe_n, lnk.host_oe_n, awake}), 16'h16);
    rst = 1'b0;
    $display("reset test finished");
    foreach (rows[i]) frame(rows[i][10:8], rows[i][7:0], 1'b0);
    frame(3'h4, 8'hc3, 1'b1);
    // Reset in mid-frame must release the line at once
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (150) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    check(16'({lnk.cs_n, lnk.dev_oe_n, busy}), 16'h6);
    rst = 1'b0;
    $display("mid-frame reset test finished");
    frame(3'h3, 8'h96, 1'b0);
    stop_test();
  end
endmodule : serial_adc_shared_line_sampling_test

// ===== include/sas_if.sv
// Interface: chip select, serial clock and one shared data wire
`timescale 1ns/1ps
interface sas_if;
  logic cs_n;
  logic sclk;
  logic dev_do;
  logic dev_oe_n;
  logic host_do;
  logic host_oe_n;
  logic data;
  // Wire resolution; pulled high when nobody drives
  assign data = !dev_oe_n ? dev_do : (!host_oe_n ? host_do : 1'b1);
  modport dev  (input cs_n, input sclk, input data, output dev_do, output dev_oe_n);
  modport host (output cs_n, output sclk, input data, output host_do, output host_oe_n);
endinterface : sas_if

// ===== include/sas_pkg.sv
// Package: shared constants for the shared-line sampling converter link
package sas_pkg;
  localparam int          CFG_BITS        = 3;      // Channel, channel, bit order
  localparam int          RESULT_BITS     = 8;
  localparam int          DRIVE_EDGE      = 4;      // Falling edges after start bit
  localparam int          CONV_CYCLES     = 8;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          WAKE_DELAY_NS   = 10000;  // Host wake-up wait
  localparam int          WAKE_CYCLES     = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SCLK_MAX_KHZ    = 500;
  localparam int          SCLK_HALF_NS    = 1000000 / (SCLK_MAX_KHZ * 2);
  localparam int          SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SCLK_HALF_MIN   = 5;      // Sync in, output flop, sync back
  localparam logic [7:0]  RESULT_RST      = 8'h00;
  localparam logic [2:0]  CFG_RST         = 3'h0;
  localparam int          BIT_ORDER_POS   = 0;      // Last config bit received
endpackage : sas_pkg

// ===== rtl/sas_dev.sv
// Device end: serial port and sequencing of the sampling converter
// Summary of operation
// - Drive line low at fourth falling edge.
// - Host releases line before device drives.
// - Active only while chip select low.
// - Pins ignored while chip select high.
// - Host waits wake delay after select.
// - Host keeps serial clock under limit.
// - Host keeps select low time short.
// - Sample window opens on bit before order.
// - Hold and convert after order bit.
// - Conversion lasts eight serial clocks.
// - First one after select is start.
// - Launch on falling, sample on rising.
// - Three config bits, null, then result.
// - Order bit picks zero fill or mirror.
`timescale 1ns/1ps
module sas_dev (
  input  wire logic       clk,
  input  wire logic       rst,
  sas_if.dev              lnk,
  input  wire logic [7:0] sample_code,
  output logic      [1:0] chan_sel,
  output logic            sample_window,
  output logic            converting,
  output logic            awake
);
  // Frame as seen from this end, one state per phase:
  //   idle  - deselected or waiting for the first one on the line
  //   cfg   - shifting in the three configuration bits
  //   wait  - order bit taken; the next falling edge starts the hold
  //   null  - line taken over, null bit standing
  //   msb   - result going out most-significant first
  //   tail  - mirror copy or zero fill until deselect
  // Every pin comes through a two-stage synchroniser, so each serial
  // clock phase must last at least three system clocks for edges to be
  // seen apart; the host end needs more than that to read the line back.

  typedef enum logic [2:0] {
    SAS_IDLE = 3'b000, SAS_CFG = 3'b001, SAS_WAIT = 3'b010,
    SAS_NULL = 3'b011, SAS_MSB = 3'b100, SAS_TAIL = 3'b101
  } sas_dst_t;

  // The counters below are three bits wide and the result register eight; refuse
  // frame constants that they could not follow
  if (sas_pkg::CFG_BITS != 3 || sas_pkg::RESULT_BITS != 8 ||
      sas_pkg::CONV_CYCLES != 8) begin : g_bad_frame
    $error("sas_dev: frame constants do not fit the counters");
  end

  // Two-stage synchronisers for every pin
  // Reset to the idle levels so no false clock edge follows reset
  logic [2:0] s1_ff, s2_ff, s3_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 3'h5;
      s2_ff <= 3'h5;
      s3_ff <= 3'h5;
    end else begin
      s1_ff <= {lnk.cs_n, lnk.sclk, lnk.data};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  wire cs_n_s = s2_ff[2];
  wire rise   = s2_ff[1] & ~s3_ff[1];
  wire fall   = ~s2_ff[1] & s3_ff[1];
  wire din    = s2_ff[0];

  sas_dst_t   st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [2:0] cfg_ff, nxt_cfg;
  logic [7:0] res_ff, nxt_res;
  logic       do_ff, nxt_do, oe_n_ff, nxt_oe_n;
  logic       win_ff, nxt_win, conv_ff, nxt_conv, awake_ff, nxt_awake;

  // Next-state logic; chip select high forces all but the held result back to idle
  // Only falling edges move the output, so the far end reads settled bits
  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_cfg   = cfg_ff;
    nxt_res   = res_ff;
    nxt_do    = do_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_win   = win_ff;
    nxt_conv  = conv_ff;
    nxt_awake = ~cs_n_s;
    if (cs_n_s) begin
      nxt_st   = SAS_IDLE;
      nxt_cnt  = 3'h0;
      nxt_cfg  = sas_pkg::CFG_RST;
      nxt_oe_n = 1'b1;
      nxt_do   = 1'b0;
      nxt_win  = 1'b0;
      nxt_conv = 1'b0;
    end else begin
      case (st_ff)
        SAS_IDLE: begin
          if (rise && din) begin
            nxt_st  = SAS_CFG;
            nxt_cnt = 3'h0;
          end
        end
        SAS_CFG: begin
          if (rise) begin
            nxt_cfg = {cfg_ff[1:0], din};
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'(sas_pkg::CFG_BITS - 2))
              nxt_win = 1'b1;
            if (cnt_ff == 3'(sas_pkg::CFG_BITS - 1))
              nxt_st = SAS_WAIT;
          end
          // Window opens as the bit before the order bit is being shifted in
          if (fall && cnt_ff == 3'(sas_pkg::CFG_BITS - 2))
            nxt_win = 1'b1;
        end
        SAS_WAIT: begin
          // Fourth falling edge after the start bit: hold, convert, take the line
          if (fall) begin                                  // first falling after order bit
            nxt_win  = 1'b0;
            nxt_conv = 1'b1;
            nxt_cnt  = 3'h0;
            nxt_res  = sample_code;                        // Held value converted
            nxt_oe_n = 1'b0;
            nxt_do   = 1'b0;                               // null bit
            nxt_st   = SAS_NULL;
          end
        end
        SAS_NULL: begin
          if (fall) begin                                  // MSB follows the null bit
            nxt_do  = res_ff[3'(sas_pkg::RESULT_BITS - 1)];
            nxt_st  = SAS_MSB;
            nxt_cnt = 3'h1;
          end
        end
        SAS_MSB: begin
          if (fall) begin                                  // launch on falling
            nxt_do  = res_ff[3'(sas_pkg::RESULT_BITS - 1) - cnt_ff];
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'(sas_pkg::CONV_CYCLES - 1)) begin
              nxt_conv = 1'b0;
              nxt_st   = SAS_TAIL;
              nxt_cnt  = 3'h1;                             // LSB-first copy skips the shared LSB
            end
          end
        end
        SAS_TAIL: begin
          if (fall) begin
            if (cfg_ff[sas_pkg::BIT_ORDER_POS] || cnt_ff == 3'h0) begin
              nxt_do = 1'b0;
              nxt_cnt = 3'h0;
            end else begin
              nxt_do  = res_ff[cnt_ff];
              nxt_cnt = cnt_ff + 3'h1;
            end
          end
        end
        default: nxt_st = SAS_IDLE;
      endcase
    end
  end

  // State registers
  // Asynchronous reset leaves the shared line released at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff    <= SAS_IDLE;
      cnt_ff   <= 3'h0;
      cfg_ff   <= sas_pkg::CFG_RST;
      res_ff   <= sas_pkg::RESULT_RST;
      do_ff    <= 1'b0;
      oe_n_ff  <= 1'b1;
      win_ff   <= 1'b0;
      conv_ff  <= 1'b0;
      awake_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      cfg_ff   <= nxt_cfg;
      res_ff   <= nxt_res;
      do_ff    <= nxt_do;
      oe_n_ff  <= nxt_oe_n;
      win_ff   <= nxt_win;
      conv_ff  <= nxt_conv;
      awake_ff <= nxt_awake;
    end
  end

  // Channel select held from configuration register
  // Follows the shifter so the selection settles before the hold edge
  logic [1:0] chan_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      chan_ff <= 2'h0;
    else
      chan_ff <= nxt_cfg[2:1];
  end

  assign lnk.dev_do    = do_ff;
  assign lnk.dev_oe_n  = oe_n_ff;
  assign chan_sel      = chan_ff;
  assign sample_window = win_ff;
  assign converting    = conv_ff;
  assign awake         = awake_ff;
endmodule : sas_dev

// ===== rtl/sas_host.sv
// Host end: drives select and clock, sends config, reads result
`timescale 1ns/1ps
module sas_host #(
  parameter int WAKE_CYC = sas_pkg::WAKE_CYCLES,
  parameter int HALF_CYC = sas_pkg::SCLK_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  sas_if.host             lnk,
  input  wire logic       start,
  input  wire logic [2:0] cfg,
  output logic [15:0]     rx_data,
  output logic            done,
  output logic            busy
);
  // Each clock phase must outlast the round trip through both synchronisers
  if (WAKE_CYC < 1 || HALF_CYC < sas_pkg::SCLK_HALF_MIN) begin : g_bad_counts
    $error("sas_host: wake or half-period count too small");
  end
  typedef enum logic [1:0] {
    SAH_IDLE = 2'b00, SAH_WAKE = 2'b01, SAH_XFER = 2'b10
  } sas_hst_t;

  // Data line synchroniser; sampled only on our own clock rise
  logic d1_ff, d2_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d1_ff <= 1'b1;
      d2_ff <= 1'b1;
    end else begin
      d1_ff <= lnk.data;
      d2_ff <= d1_ff;
    end
  end

  sas_hst_t    st_ff, nxt_st;
  logic [31:0] tmr_ff, nxt_tmr;
  logic [5:0]  bit_ff, nxt_bit;
  logic [3:0]  tx_ff, nxt_tx;
  logic [15:0] rx_ff, nxt_rx;
  logic        cs_ff, nxt_cs, sclk_ff, nxt_sclk, do_ff, nxt_do, oe_n_ff, nxt_oe_n;
  logic        done_ff, nxt_done;
  logic        busy_ff, nxt_busy;

  // Frame: start bit + 3 config, release, null, 16 result bits
  always_comb begin
    nxt_st   = st_ff;
    nxt_tmr  = tmr_ff;
    nxt_bit  = bit_ff;
    nxt_tx   = tx_ff;
    nxt_rx   = rx_ff;
    nxt_cs   = cs_ff;
    nxt_sclk = sclk_ff;
    nxt_do   = do_ff;
    nxt_oe_n = oe_n_ff;
    nxt_done = 1'b0;
    case (st_ff)
      SAH_IDLE: begin
        if (start) begin
          nxt_cs  = 1'b0;
          nxt_tmr = 32'(WAKE_CYC);
          nxt_tx  = {1'b1, cfg};
          nxt_bit = 6'h0;
          nxt_st  = SAH_WAKE;
        end
      end
      SAH_WAKE: begin
        if (tmr_ff == 32'h0) begin
          nxt_do   = tx_ff[3];                             // Start bit set up
          nxt_oe_n = 1'b0;
          nxt_tmr  = 32'(HALF_CYC);
          nxt_st   = SAH_XFER;
        end else
          nxt_tmr = tmr_ff - 32'h1;
      end
      SAH_XFER: begin
        if (tmr_ff != 32'h0)
          nxt_tmr = tmr_ff - 32'h1;
        else begin
          nxt_tmr  = 32'(HALF_CYC);
          nxt_sclk = ~sclk_ff;
          if (!sclk_ff) begin
            // Rising edge: capture result bits (after null)
            if (bit_ff >= 6'd5)
              nxt_rx = {rx_ff[14:0], d2_ff};
          end else begin
            // Falling edge: launch next bit or release line
            nxt_bit = bit_ff + 6'h1;
            if (bit_ff < 6'd3) begin
              nxt_tx = {tx_ff[2:0], 1'b0};
              nxt_do = tx_ff[2];
            end else
              nxt_oe_n = 1'b1;                             // released at 4th fall, before device drives
            if (bit_ff == 6'd20) begin
              nxt_cs   = 1'b1;
              nxt_done = 1'b1;
              nxt_st   = SAH_IDLE;
            end
          end
        end
      end
      default: nxt_st = SAH_IDLE;
    endcase
    nxt_busy = (nxt_st != SAH_IDLE);                       // Registered so the output is clean
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff   <= SAH_IDLE;
      tmr_ff  <= 32'h0;
      bit_ff  <= 6'h0;
      tx_ff   <= 4'h0;
      rx_ff   <= 16'h0;
      cs_ff   <= 1'b1;
      sclk_ff <= 1'b0;
      do_ff   <= 1'b0;
      oe_n_ff <= 1'b1;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      tmr_ff  <= nxt_tmr;
      bit_ff  <= nxt_bit;
      tx_ff   <= nxt_tx;
      rx_ff   <= nxt_rx;
      cs_ff   <= nxt_cs;
      sclk_ff <= nxt_sclk;
      do_ff   <= nxt_do;
      oe_n_ff <= nxt_oe_n;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
    end
  end

  assign lnk.cs_n      = cs_ff;
  assign lnk.sclk      = sclk_ff;
  assign lnk.host_do   = do_ff;
  assign lnk.host_oe_n = oe_n_ff;
  assign rx_data       = rx_ff;
  assign done          = done_ff;
  assign busy          = busy_ff;
endmodule : sas_host
